// File: bwsr_defs.svh
`ifndef BWSR_DEFS_SVH
`define BWSR_DEFS_SVH

// =====================================================================
// register addresses (7-bit)
`define BWSR_ADDR_DEV_INFO   7'h43
`define BWSR_ADDR_BUS_STAT   7'h44
`define BWSR_ADDR_WAKE_0     7'h46
`define BWSR_ADDR_WAKE_1     7'h47
`define BWSR_ADDR_IN_LEVEL   7'h48

// =====================================================================
// field positions
`define BWSR_PRIOR_HI        7
`define BWSR_PRIOR_LO        6
`define BWSR_WDF_HI          3
`define BWSR_WDF_LO          2
`define BWSR_CMDERR_BIT      1
`define BWSR_FAILURE_BIT     0
`define BWSR_CANFAIL_HI      2
`define BWSR_CANFAIL_LO      1
`define BWSR_CANUV_BIT       0
`define BWSR_CANWK_BIT       5
`define BWSR_TMRWK_BIT       4
`define BWSR_HVWK_BIT        0
`define BWSR_GPWK_BIT        4
`define BWSR_DEVMODE_BIT     7
`define BWSR_STRAP_BIT       6
`define BWSR_GPLVL_BIT       4
`define BWSR_HVLVL_BIT       0
`define BWSR_CANMODE_UP_BIT  1

// =====================================================================
// reset values and codes
`define BWSR_RESET_BYTE      8'h00
`define BWSR_PRIOR_CLEAR     2'h0
`define BWSR_PRIOR_FAIL      2'h1
`define BWSR_PRIOR_SLEEP     2'h2
`define BWSR_WDF_MAX         2'h2
`define BWSR_STRAP_WAIT      2'h2

`endif

// File: bwsr_pkg.sv
package bwsr_pkg;

   // chip operating mode as seen by this block
   typedef enum logic [2:0] {
      BWSR_MODE_INIT,
      BWSR_MODE_NORMAL,
      BWSR_MODE_STOP,
      BWSR_MODE_SLEEP,
      BWSR_MODE_RESTART,
      BWSR_MODE_FAILSAFE
   } bwsr_mode_t;

   // general-purpose pin use
   typedef enum logic [1:0] {
      BWSR_GP_OFF,
      BWSR_GP_FAIL_OUT,
      BWSR_GP_WAKE_IN,
      BWSR_GP_SWITCH
   } bwsr_gp_cfg_t;

   // one-cycle events from the analog and mode logic
   typedef struct packed {
      logic       can_thermal;
      logic       can_txd_dom;
      logic       can_bus_dom;
      logic       can_supply_low;
      logic       can_wake;
      logic       timer_wake;
      logic       hv_wake;
      logic       gp_wake;
      logic       watchdog_fault_counter;
      logic       wd_good;
      logic       cmd_invalid;
      logic       fail_out;
   } bwsr_evt_t;

   // register access from the serial shell
   typedef struct packed {
      logic       rd;
      logic       clr;
      logic [6:0] addr;
   } bwsr_acc_t;

endpackage : bwsr_pkg

// File: bwsr_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a group of pin levels
module bwsr_sync #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // =====================================================================
   // first stage feeds only the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : bwsr_sync

// File: bwsr_level.sv
`timescale 1ns/1ps
`include "bwsr_defs.svh"
// live pin level tracking for the input level register
module bwsr_level
   import bwsr_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire bwsr_mode_t   mode,
   input  wire bwsr_gp_cfg_t gp_cfg,
   input  wire logic         cyclic_gp,
   input  wire logic         cyclic_sample,
   input  wire logic         meas_en,
   input  wire logic         hv_pin,
   input  wire logic         gp_pin,
   output logic              hv_lvl,
   output logic              gp_lvl
);
   logic live_mode;
   logic gp_ok;

   // =====================================================================
   // refresh in active modes, otherwise only on a sample strobe
   assign live_mode = (mode == BWSR_MODE_NORMAL) || (mode == BWSR_MODE_STOP)
                   || (mode == BWSR_MODE_INIT) || (mode == BWSR_MODE_RESTART);
   assign gp_ok = (gp_cfg == BWSR_GP_WAKE_IN)
               || ((gp_cfg == BWSR_GP_SWITCH) && !cyclic_gp);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hv_lvl <= 1'b0;
         gp_lvl <= 1'b0;
      end else if (meas_en) begin
         hv_lvl <= 1'b0;
         gp_lvl <= 1'b0;
      end else if (live_mode || cyclic_sample) begin
         hv_lvl <= hv_pin;
         if (gp_ok) begin
            gp_lvl <= gp_pin;
         end
      end
   end
endmodule : bwsr_level

// File: bwsr_status.sv
`timescale 1ns/1ps
`include "bwsr_defs.svh"
// What this block does
// - prior-state field records condition before leaving restart mode.
// - prior-state codes 00 clear, 01 failure, 10 sleep; held until cleared.
// - sleep request with wake flags pending reports sleep origin.
// - watchdog fault counter counts; chip clears only it by itself.
// - invalid-command flag clears only by a serial clear command.
// - configs 2/4 freeze watchdog counter after fail until good trigger.
// - bus status at 0x44; restart keeps bits 2:0, resets clear all.
// - bits 2:1 code CAN fault: thermal, txd dominant, bus dominant.
// - CAN supply low sets bit 0 and disables the transmitter.
// - CAN supply comparator active only when CAN mode upper bit set.
// - wake ending fail-safe also sets matching source flag.
// - wake register 1 bit 4 latches gp pin wake when wake input.
// - input level bit 7 shows development mode from test pin.
// - input level bit 6 shows interrupt pin pull-up strap.
// - input level bits 4 and 0 show live gp and hv pin levels.
// - levels refresh in active modes, else after each cyclic sample.
// - gp level updates only as wake input or non-cyclic switch.
// - measurement enable holds hv and gp level bits at zero.
// - reserved bits always read zero.
module bwsr_status
   import bwsr_pkg::*;
(
   input  wire logic         MCLK,
   input  wire logic         RST,
   input  wire logic         SOFT_RST,
   input  wire logic         RESTART,
   input  wire bwsr_mode_t   MODE,
   input  wire logic         SLEEP_REQ,
   input  wire logic         FAIL_RESTART,
   input  wire logic [1:0]   CAN_MODE,
   input  wire bwsr_gp_cfg_t GP_CFG,
   input  wire logic         CYCLIC_GP,
   input  wire logic         CYCLIC_SAMPLE,
   input  wire logic         HV_MEASURE_ENABLE,
   input  wire bwsr_evt_t    EVT,
   input  wire bwsr_acc_t    ACC,
   input  wire logic         TEST_PIN,
   input  wire logic         INTERRUPT_OUT_PIN,
   input  wire logic         HV_WAKE_PIN,
   input  wire logic         GP_PIN,
   output logic [7:0]        RDATA,
   output logic              RVALID,
   output logic              CAN_TX_DISABLE
);
   logic [1:0]   prior_state_field_reg;
   logic [1:0]   watchdog_fault_counter_reg;
   logic         wdf_frozen_reg;
   logic         cmd_error_reg;
   logic         failure_reg;
   logic [1:0]   can_fail_reg;
   logic         can_supply_low_flag_reg;
   logic         can_wake_flag_reg;
   logic         timer_wake_flag_reg;
   logic         hv_pin_wake_flag_reg;
   logic         gp_pin_wake_flag_reg;
   logic         development_mode_level_reg;
   logic         config_strap_level_reg;
   logic         strap_taken_reg;
   logic [1:0]   strap_wait_reg;
   logic         hv_pin_level;
   logic         gp_pin_level;
   logic [3:0]   pins_sync;
   logic         wake_pending;
   logic         from_failsafe;
   logic         strap_cfg24;
   logic         clr_bus;
   logic         clr_w0;
   logic         clr_w1;
   logic         clr_dev;
   logic [7:0]   rdata_next;

   // =====================================================================
   // pin synchronisers
   bwsr_sync #(.W(4)) u_sync (
      .clk (MCLK),
      .rst (RST),
      .d   ({TEST_PIN, INTERRUPT_OUT_PIN, HV_WAKE_PIN, GP_PIN}),
      .q   (pins_sync)
   );

   // =====================================================================
   // live levels
   bwsr_level u_level (
      .clk           (MCLK),
      .rst           (RST),
      .mode          (MODE),
      .gp_cfg        (GP_CFG),
      .cyclic_gp     (CYCLIC_GP),
      .cyclic_sample (CYCLIC_SAMPLE),
      .meas_en       (HV_MEASURE_ENABLE),
      .hv_pin        (pins_sync[1]),
      .gp_pin        (pins_sync[0]),
      .hv_lvl        (hv_pin_level),
      .gp_lvl        (gp_pin_level)
   );

   // =====================================================================
   // clear strobes per register
   function automatic logic hit(input bwsr_acc_t a, input logic [6:0] adr);
      hit = a.clr && (a.addr == adr);
   endfunction : hit

   assign clr_bus = hit(ACC, `BWSR_ADDR_BUS_STAT);
   assign clr_w0  = hit(ACC, `BWSR_ADDR_WAKE_0);
   assign clr_w1  = hit(ACC, `BWSR_ADDR_WAKE_1);
   assign clr_dev = hit(ACC, `BWSR_ADDR_DEV_INFO);
   assign wake_pending = can_wake_flag_reg | timer_wake_flag_reg
                       | hv_pin_wake_flag_reg | gp_pin_wake_flag_reg;
   assign from_failsafe = (MODE == BWSR_MODE_FAILSAFE);
   assign strap_cfg24 = !config_strap_level_reg;

   // =====================================================================
   // strap capture after reset release, never in the reset branch
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         strap_taken_reg            <= 1'b0;
         strap_wait_reg             <= 2'h0;
         development_mode_level_reg <= 1'b0;
         config_strap_level_reg     <= 1'b0;
      end else begin
         development_mode_level_reg <= pins_sync[3];
         // synchroniser shows its reset value until two edges have passed
         if (strap_wait_reg != `BWSR_STRAP_WAIT) begin
            strap_wait_reg <= strap_wait_reg + 2'h1;
         end else if (!strap_taken_reg) begin
            strap_taken_reg        <= 1'b1;
            config_strap_level_reg <= pins_sync[2];
         end
      end
   end

   // =====================================================================
   // prior-state field; held across restart, cleared by software
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         prior_state_field_reg <= `BWSR_PRIOR_CLEAR;
      end else if (SOFT_RST) begin
         prior_state_field_reg <= `BWSR_PRIOR_CLEAR;
      end else if (SLEEP_REQ && wake_pending) begin
         prior_state_field_reg <= `BWSR_PRIOR_SLEEP;
      end else if (FAIL_RESTART) begin
         prior_state_field_reg <= `BWSR_PRIOR_FAIL;
      end else if (from_failsafe && (EVT.can_wake || EVT.timer_wake
                   || EVT.hv_wake || EVT.gp_wake)) begin
         prior_state_field_reg <= `BWSR_PRIOR_FAIL;
      end else if (SLEEP_REQ) begin
         prior_state_field_reg <= `BWSR_PRIOR_SLEEP;
      end else if (clr_dev) begin
         prior_state_field_reg <= `BWSR_PRIOR_CLEAR;
      end
   end

   // =====================================================================
   // watchdog counter; self-clears on good trigger except when frozen in cfg 2/4
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         watchdog_fault_counter_reg <= 2'h0;
         wdf_frozen_reg             <= 1'b0;
      end else if (SOFT_RST) begin
         watchdog_fault_counter_reg <= 2'h0;
         wdf_frozen_reg             <= 1'b0;
      end else if (EVT.wd_good) begin
         wdf_frozen_reg <= 1'b0;
         if (!wdf_frozen_reg || !strap_cfg24) begin
            watchdog_fault_counter_reg <= 2'h0;
         end
      end else if (EVT.watchdog_fault_counter) begin
         if (strap_cfg24) begin
            wdf_frozen_reg <= 1'b1;
         end
         if (!(strap_cfg24 && wdf_frozen_reg)
             && watchdog_fault_counter_reg != `BWSR_WDF_MAX) begin
            watchdog_fault_counter_reg <=
               watchdog_fault_counter_reg + 2'h1;
         end
      end
   end

   // =====================================================================
   // invalid command and failure flags; set beats clear
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         cmd_error_reg <= 1'b0;
         failure_reg   <= 1'b0;
      end else if (SOFT_RST) begin
         cmd_error_reg <= 1'b0;
         failure_reg   <= 1'b0;
      end else begin
         if (EVT.cmd_invalid) begin
            cmd_error_reg <= 1'b1;
         end else if (clr_dev) begin
            cmd_error_reg <= 1'b0;
         end
         if (EVT.fail_out) begin
            failure_reg <= 1'b1;
         end else if (clr_dev) begin
            failure_reg <= 1'b0;
         end
      end
   end

   // =====================================================================
   // bus status; restart keeps all stored bits (all sit in 2:0)
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         can_fail_reg            <= 2'h0;
         can_supply_low_flag_reg <= 1'b0;
      end else if (SOFT_RST) begin
         can_fail_reg            <= 2'h0;
         can_supply_low_flag_reg <= 1'b0;
      end else begin
         if (EVT.can_bus_dom) begin
            can_fail_reg <= 2'h3;
         end else if (EVT.can_txd_dom) begin
            can_fail_reg <= 2'h2;
         end else if (EVT.can_thermal) begin
            can_fail_reg <= 2'h1;
         end else if (clr_bus) begin
            can_fail_reg <= 2'h0;
         end
         if (EVT.can_supply_low
             && CAN_MODE[`BWSR_CANMODE_UP_BIT]) begin
            can_supply_low_flag_reg <= 1'b1;
         end else if (clr_bus) begin
            can_supply_low_flag_reg <= 1'b0;
         end
      end
   end

   // =====================================================================
   // wake source flags; fail-safe wakes set them the same way
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         can_wake_flag_reg    <= 1'b0;
         timer_wake_flag_reg  <= 1'b0;
         hv_pin_wake_flag_reg <= 1'b0;
         gp_pin_wake_flag_reg <= 1'b0;
      end else if (SOFT_RST) begin
         can_wake_flag_reg    <= 1'b0;
         timer_wake_flag_reg  <= 1'b0;
         hv_pin_wake_flag_reg <= 1'b0;
         gp_pin_wake_flag_reg <= 1'b0;
      end else begin
         // holds because the sets ignore the current mode
         can_wake_flag_reg    <= EVT.can_wake
                              | (can_wake_flag_reg & ~clr_w0);
         timer_wake_flag_reg  <= EVT.timer_wake
                              | (timer_wake_flag_reg & ~clr_w0);
         hv_pin_wake_flag_reg <= EVT.hv_wake
                              | (hv_pin_wake_flag_reg & ~clr_w0);
         gp_pin_wake_flag_reg <= (EVT.gp_wake
                              && GP_CFG == BWSR_GP_WAKE_IN)
                              | (gp_pin_wake_flag_reg & ~clr_w1);
      end
   end

   // =====================================================================
   // transmitter off while supply low is flagged
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         CAN_TX_DISABLE <= 1'b0;
      end else begin
         CAN_TX_DISABLE <= can_supply_low_flag_reg;
      end
   end

   // =====================================================================
   // read mux; reserved bits are zero, unknown addresses read zero
   always_comb begin
      rdata_next = `BWSR_RESET_BYTE;
      if (ACC.addr == `BWSR_ADDR_DEV_INFO) begin
         rdata_next[`BWSR_PRIOR_HI:`BWSR_PRIOR_LO] = prior_state_field_reg;
         rdata_next[`BWSR_WDF_HI:`BWSR_WDF_LO] = watchdog_fault_counter_reg;
         rdata_next[`BWSR_CMDERR_BIT]  = cmd_error_reg;
         rdata_next[`BWSR_FAILURE_BIT] = failure_reg;
      end else if (ACC.addr == `BWSR_ADDR_BUS_STAT) begin
         rdata_next[`BWSR_CANFAIL_HI:`BWSR_CANFAIL_LO] = can_fail_reg;
         rdata_next[`BWSR_CANUV_BIT] = can_supply_low_flag_reg;
      end else if (ACC.addr == `BWSR_ADDR_WAKE_0) begin
         rdata_next[`BWSR_CANWK_BIT] = can_wake_flag_reg;
         rdata_next[`BWSR_TMRWK_BIT] = timer_wake_flag_reg;
         rdata_next[`BWSR_HVWK_BIT]  = hv_pin_wake_flag_reg;
      end else if (ACC.addr == `BWSR_ADDR_WAKE_1) begin
         rdata_next[`BWSR_GPWK_BIT] = gp_pin_wake_flag_reg;
      end else if (ACC.addr == `BWSR_ADDR_IN_LEVEL) begin
         rdata_next[`BWSR_DEVMODE_BIT] = development_mode_level_reg;
         rdata_next[`BWSR_STRAP_BIT]   = config_strap_level_reg;
         rdata_next[`BWSR_GPLVL_BIT]   = gp_pin_level;
         rdata_next[`BWSR_HVLVL_BIT]   = hv_pin_level;
      end
   end

   // =====================================================================
   // read data registered: value before any same-cycle clear
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         RDATA  <= `BWSR_RESET_BYTE;
         RVALID <= 1'b0;
      end else begin
         RVALID <= ACC.rd | ACC.clr;
         if (ACC.rd || ACC.clr) begin
            RDATA <= rdata_next;
         end
      end
   end

   // RESTART input is accepted for the mode interface; every stored bit
   // here survives restart, so it needs no action of its own
   logic restart_unused;
   assign restart_unused = RESTART;

endmodule : bwsr_status

// File: bwsr_status_properties.sv
`timescale 1ns/1ps
// ====================
// port checks for the status bank
module bwsr_status_properties
   import bwsr_pkg::*;
(
   input wire logic       MCLK,
   input wire logic       RST,
   input wire logic [1:0] CAN_MODE,
   input wire bwsr_gp_cfg_t GP_CFG,
   input wire logic       HV_MEASURE_ENABLE,
   input wire bwsr_evt_t  EVT,
   input wire bwsr_acc_t  ACC,
   input wire logic       TEST_PIN,
   input wire logic [7:0] RDATA,
   input wire logic       RVALID,
   input wire logic       CAN_TX_DISABLE
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   // reserved positions of the bus status and wake 1 answers
   AST_BUS_RSVD: assert property (
      RVALID && $past(ACC.addr) == 7'h44 |-> RDATA[7:3] == 5'h00)
      else $error("bus byte reserved bits set");
   AST_WAKE1_RSVD: assert property (
      RVALID && $past(ACC.addr) == 7'h47 |-> {RDATA[7:5], RDATA[3:0]} == 7'h00)
      else $error("wake1 byte reserved bits set");
   // fault code and supply flag
   AST_BUS_DOM: assert property (
      EVT.can_bus_dom ##2 (ACC.rd && ACC.addr == 7'h44)
      |=> RDATA[2:1] == 2'h3) else $error("bus dominant code wrong");
   AST_TX_OFF: assert property (
      EVT.can_supply_low && CAN_MODE[1] |-> ##[1:2] CAN_TX_DISABLE)
      else $error("transmitter not disabled");
   AST_UV_GATE: assert property (
      $rose(CAN_TX_DISABLE) |-> $past(CAN_MODE[1], 2))
      else $error("supply flag set with comparator off");
   // wake latches
   AST_TMR_WAKE: assert property (
      EVT.timer_wake ##2 (ACC.rd && ACC.addr == 7'h46) |=> RDATA[4])
      else $error("timer wake not latched");
   AST_GP_WAKE: assert property (
      EVT.gp_wake && GP_CFG == BWSR_GP_WAKE_IN ##2
      (ACC.rd && ACC.addr == 7'h47) |=> RDATA[4])
      else $error("gp wake not latched");
   AST_CLEARED: assert property (
      ACC.clr && ACC.addr == 7'h46 ##0 (EVT == '0)[*2]
      ##1 (ACC.rd && ACC.addr == 7'h46) |=> RDATA == 8'h00)
      else $error("wake0 not cleared");
   // level byte: mode pin and measurement hold
   AST_DEV_LVL: assert property (
      RVALID && $past(ACC.rd) && $past(ACC.addr) == 7'h48
      && $past(TEST_PIN, 5) == TEST_PIN && $past(TEST_PIN, 3) == TEST_PIN
      |-> RDATA[7] == TEST_PIN) else $error("mode bit wrong");
   AST_MEAS_HOLD: assert property (
      RVALID && $past(ACC.addr) == 7'h48 && $past(HV_MEASURE_ENABLE, 5)
      && $past(HV_MEASURE_ENABLE) |-> RDATA[4] == 1'b0 && RDATA[0] == 1'b0)
      else $error("level bits not held low");
endmodule : bwsr_status_properties

bind bwsr_status bwsr_status_properties u_props (
   .MCLK(MCLK), .RST(RST), .CAN_MODE(CAN_MODE), .GP_CFG(GP_CFG),
   .HV_MEASURE_ENABLE(HV_MEASURE_ENABLE), .EVT(EVT), .ACC(ACC),
   .TEST_PIN(TEST_PIN), .RDATA(RDATA), .RVALID(RVALID),
   .CAN_TX_DISABLE(CAN_TX_DISABLE));

// File: bwsr_host.sv
`timescale 1ns/1ps
// ====================
// controller side: one-byte read or clear
module bwsr_host
   import bwsr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] rdata,
   input  wire logic       rvalid,
   output bwsr_acc_t       acc
);
   initial acc = '0;
   // idle address is scrambled so a stale match cannot pass
   task automatic xfer(input logic rd, input logic clr,
                       input logic [6:0] a, output logic [7:0] d);
      @(negedge clk);
      acc = '{rd: rd, clr: clr, addr: a};
      @(negedge clk);
      d = (rvalid === 1'b1) ? rdata : 8'hXX; // answer only while valid
      acc = '{rd: 1'b0, clr: 1'b0, addr: ~a};
   endtask : xfer
endmodule : bwsr_host

// File: bwsr_status_tb.sv
`timescale 1ns/1ps
module bwsr_status_tb;
   import bwsr_pkg::*;
   typedef struct packed {
      bwsr_evt_t    evt;
      logic [1:0]   canm;
      bwsr_gp_cfg_t gp;
      logic [6:0]   addr;
      logic [7:0]   exp;
   } bwsr_row_t;
   logic         MCLK, RST, SOFT_RST, RESTART, SLEEP_REQ, FAIL_RESTART;
   logic         CYCLIC_SAMPLE, HV_MEASURE_ENABLE, TEST_PIN, GP_PIN, CYCLIC_GP;
   logic         INTERRUPT_OUT_PIN, HV_WAKE_PIN, RVALID, CAN_TX_DISABLE;
   logic [1:0]   CAN_MODE;
   logic [7:0]   RDATA, d;
   bwsr_mode_t   MODE;
   bwsr_gp_cfg_t GP_CFG;
   bwsr_evt_t    EVT;
   bwsr_acc_t    ACC;
   bwsr_row_t    rows [11];
   logic [6:0]   ra [4] = '{7'h43, 7'h44, 7'h46, 7'h47};
   int           num_errors, comparisons, cycles;

   // ====================
   // design and controller
   bwsr_status DUT (.MCLK(MCLK), .RST(RST), .SOFT_RST(SOFT_RST),
      .RESTART(RESTART), .MODE(MODE), .SLEEP_REQ(SLEEP_REQ),
      .FAIL_RESTART(FAIL_RESTART), .CAN_MODE(CAN_MODE), .GP_CFG(GP_CFG),
      .CYCLIC_GP(CYCLIC_GP), .CYCLIC_SAMPLE(CYCLIC_SAMPLE),
      .HV_MEASURE_ENABLE(HV_MEASURE_ENABLE), .EVT(EVT), .ACC(ACC),
      .TEST_PIN(TEST_PIN), .INTERRUPT_OUT_PIN(INTERRUPT_OUT_PIN),
      .HV_WAKE_PIN(HV_WAKE_PIN), .GP_PIN(GP_PIN), .RDATA(RDATA),
      .RVALID(RVALID), .CAN_TX_DISABLE(CAN_TX_DISABLE));
   bwsr_host host (.clk(MCLK), .rdata(RDATA), .rvalid(RVALID), .acc(ACC));

   // 25 MHz clock
   initial begin
      MCLK = 1'b0;
      forever #20 MCLK = ~MCLK;
   end
   // hang guard, well above the few hundred cycles needed
   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         report_and_stop();
      end
   end

   // ====================
   // helpers
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic access(input logic c, input logic [6:0] a,
                         input logic [7:0] e);
      host.xfer(!c, c, a, d);
      comparisons++;
      if (d !== e) begin
         num_errors++;
         $display("MISMATCH at %0t: addr %h got %h want %h", $time, a, d, e);
      end
   endtask : access
   task automatic pulse(input bwsr_evt_t e, input logic [4:0] c);
      @(negedge MCLK);
      EVT = e;
      {SLEEP_REQ, FAIL_RESTART, RESTART, SOFT_RST, CYCLIC_SAMPLE} = c;
      @(negedge MCLK);
      EVT = '0;
      {SLEEP_REQ, FAIL_RESTART, RESTART, SOFT_RST, CYCLIC_SAMPLE} = 5'h00;
   endtask : pulse
   task automatic idle(input int n);
      repeat (n) @(negedge MCLK);
   endtask : idle

   // ====================
   // main sequence
   initial begin
      num_errors = 0; comparisons = 0; cycles = 0;
      RST = 1'b1; SOFT_RST = 1'b0; RESTART = 1'b0; SLEEP_REQ = 1'b0;
      FAIL_RESTART = 1'b0; CYCLIC_SAMPLE = 1'b0; HV_MEASURE_ENABLE = 1'b0;
      TEST_PIN = 1'b1; INTERRUPT_OUT_PIN = 1'b1; HV_WAKE_PIN = 1'b1;
      GP_PIN = 1'b1; CAN_MODE = 2'h0; MODE = BWSR_MODE_NORMAL;
      GP_CFG = BWSR_GP_OFF; EVT = '0; CYCLIC_GP = 1'b0;
      rows[0] = '{12'h800, 2'h0, BWSR_GP_OFF, 7'h44, 8'h02};
      rows[1] = '{12'h400, 2'h0, BWSR_GP_OFF, 7'h44, 8'h04};
      rows[2] = '{12'h200, 2'h0, BWSR_GP_OFF, 7'h44, 8'h06};
      rows[3] = '{12'h100, 2'h2, BWSR_GP_OFF, 7'h44, 8'h01};
      rows[4] = '{12'h100, 2'h1, BWSR_GP_OFF, 7'h44, 8'h00};
      rows[5] = '{12'h080, 2'h0, BWSR_GP_OFF, 7'h46, 8'h20};
      rows[6] = '{12'h040, 2'h0, BWSR_GP_OFF, 7'h46, 8'h10};
      rows[7] = '{12'h020, 2'h0, BWSR_GP_OFF, 7'h46, 8'h01};
      rows[8] = '{12'h010, 2'h0, BWSR_GP_WAKE_IN, 7'h47, 8'h10};
      rows[9] = '{12'h010, 2'h0, BWSR_GP_OFF, 7'h47, 8'h00};
      rows[10] = '{12'h000, 2'h0, BWSR_GP_OFF, 7'h45, 8'h00};
      idle(10);
      RST = 1'b0;
      foreach (ra[i]) access(0, ra[i], 8'h00);
      $display("reset values done");
      // table: latch, survive, clear
      foreach (rows[i]) begin
         CAN_MODE = rows[i].canm;
         GP_CFG = rows[i].gp;
         pulse(rows[i].evt, 5'h00);
         access(0, rows[i].addr, rows[i].exp);
         access(1, rows[i].addr, rows[i].exp);
         access(0, rows[i].addr, 8'h00);
      end
      $display("flag table done");
      // prior-state codes and their precedence
      pulse('0, 5'h10);
      access(0, 7'h43, 8'h80);
      access(1, 7'h43, 8'h80);
      pulse('0, 5'h08);
      access(1, 7'h43, 8'h40);
      pulse(12'h080, 5'h00);
      pulse('0, 5'h18);
      access(1, 7'h43, 8'h80);
      access(1, 7'h46, 8'h20);
      pulse(12'h002, 5'h00);
      access(1, 7'h43, 8'h02);
      access(0, 7'h43, 8'h00);
      // counter saturates, survives a clear, drops on good trigger
      repeat (3) pulse(12'h008, 5'h00);
      access(1, 7'h43, 8'h08);
      access(0, 7'h43, 8'h08);
      pulse(12'h004, 5'h00);
      access(0, 7'h43, 8'h00);
      MODE = BWSR_MODE_FAILSAFE;
      pulse(12'h020, 5'h00);
      MODE = BWSR_MODE_NORMAL;
      access(1, 7'h46, 8'h01);
      access(1, 7'h43, 8'h40);
      // restart keeps the fault, soft reset drops it
      pulse(12'h200, 5'h04);
      access(0, 7'h44, 8'h06);
      pulse('0, 5'h02);
      access(0, 7'h44, 8'h00);
      $display("device info done");
      // live levels
      GP_CFG = BWSR_GP_WAKE_IN;
      idle(6);
      access(0, 7'h48, 8'hD1);
      HV_MEASURE_ENABLE = 1'b1;
      idle(6);
      access(0, 7'h48, 8'hC0);
      HV_MEASURE_ENABLE = 1'b0;
      GP_CFG = BWSR_GP_OFF;
      idle(6);
      access(1, 7'h48, 8'hC1);
      GP_CFG = BWSR_GP_SWITCH;
      CYCLIC_GP = 1'b1;
      idle(6);
      access(0, 7'h48, 8'hC1);
      CYCLIC_GP = 1'b0;
      GP_CFG = BWSR_GP_OFF;
      MODE = BWSR_MODE_SLEEP;
      HV_WAKE_PIN = 1'b0;
      idle(6);
      access(0, 7'h48, 8'hC1);
      pulse('0, 5'h01);
      idle(2);
      access(0, 7'h48, 8'hC0);
      $display("levels done");
      // second power-on without strap pull-up: frozen counter
      MODE = BWSR_MODE_NORMAL;
      GP_CFG = BWSR_GP_WAKE_IN;
      HV_WAKE_PIN = 1'b1;
      INTERRUPT_OUT_PIN = 1'b0;
      TEST_PIN = 1'b0;
      RST = 1'b1;
      idle(10);
      RST = 1'b0;
      idle(6);
      access(0, 7'h48, 8'h11);
      repeat (2) pulse(12'h008, 5'h00);
      access(0, 7'h43, 8'h04);
      $display("second reset done");
      report_and_stop();
   end
endmodule : bwsr_status_tb
